// ==== hw/wwd_pkg.sv ====
/*
  windowed watchdog package: register offsets, field positions, reset
  values and the feed sequence states shared by the watchdog design.
  assumes a byte address bus whose register words sit on aligned offsets.
*/
package wwd_pkg;

  // ********************************
  // bus and register map
  // ********************************
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_MODE = 8'h00;
  localparam logic [ADR_W-1:0] ADR_RELOAD = 8'h04;
  localparam logic [ADR_W-1:0] ADR_FEED = 8'h08;
  localparam logic [ADR_W-1:0] ADR_VALUE = 8'h0c;
  localparam logic [ADR_W-1:0] ADR_WARN = 8'h14;
  localparam logic [ADR_W-1:0] ADR_WINDOW = 8'h18;

  // ********************************
  // mode register fields
  // ********************************
  localparam int BIT_EN = 0;
  localparam int BIT_RST = 1;
  localparam int BIT_TOF = 2;
  localparam int BIT_WINT = 3;
  localparam int BIT_PROT = 4;

  // ********************************
  // values after reset and keys
  // ********************************
  localparam logic [23:0] RST_RELOAD = 24'h0000ff;
  localparam logic [23:0] MIN_RELOAD = 24'h0000ff;
  localparam logic [23:0] RST_CNT = 24'h0000ff;
  localparam logic [23:0] RST_WARN = 24'h000000;
  localparam logic [23:0] RST_WINDOW = 24'hffffff;
  localparam logic [7:0] FEED_KEY1 = 8'haa;
  localparam logic [7:0] FEED_KEY2 = 8'h55;

  // ********************************
  // counts of counting clock cycles, and the config word width
  // ********************************
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam int CFG_DELAY = 3;
  localparam int CFG_W = 27;

  // feed sequence tracker
  typedef enum logic [1:0] {
    FD_IDLE = 2'b01,
    FD_ARMED = 2'b10
  } wwd_feed_st_t;

endpackage

// ==== hw/wwd_top.sv ====
/*
  windowed watchdog: apb register slave, feed sequence tracker, divide by
  four prescaler, 24-bit down counter, window, warning and reload lock.
  assumes a single clock; the counting clock arrives as a level synchronous
  to clk_in and slower than half its rate; ext_por_in is high together with
  a low reset_n_in only when the reset comes from outside the chip.
*/
`timescale 1ns/100ps
module wwd_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ext_por_in,
  input wire logic counting_clock_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [wwd_pkg::ADR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic chip_reset_out,
  output logic warning_irq_out
);
  import wwd_pkg::*;

  logic cc_q, cc_edge, dec_en, en_bit, rst_bit, prot_bit, timeout_flag, warning_flag;
  logic [1:0] presc;
  logic [23:0] reload, warn_cmp, window, cnt, cap, cap_s1, cap_s2;
  logic run, rst_active, feed_pend;
  wwd_feed_st_t fstate;
  logic acc, wr, setup, wr_mode, wr_reload, refuse, feed_ok;
  logic feed_err, win_err, prot_err, expire, warn_hit, wd_event;
  logic [CFG_W-1:0] cfg_word;
  logic [CFG_W-1:0] pipe [CFG_DELAY];

  // ********************************
  // apb decode
  // ********************************
  // one access phase per transfer; pready stays high after reset
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;
  assign setup = psel_in & ~penable_in;
  assign wr_mode = wr && (paddr_in == ADR_MODE);
  assign wr_reload = wr && (paddr_in == ADR_RELOAD);

  // ********************************
  // watchdog events
  // ********************************
  // lock holds while the count is still above the warning time
  assign refuse = prot_bit && (cnt > warn_cmp);
  assign prot_err = wr_reload & refuse;
  assign feed_ok = (fstate == FD_ARMED) && wr && (paddr_in == ADR_FEED)
    && (pwdata_in[7:0] == FEED_KEY2);
  // feed and window errors before the first running feed are ignored
  assign feed_err = (fstate == FD_ARMED) && acc && !feed_ok && run;
  assign win_err = feed_ok && run && (cnt > window);
  assign expire = dec_en && run && (cnt == 24'h000000);
  // compare with the next count so the flag lines up with the match
  assign warn_hit = dec_en && run && (warn_cmp != RST_WARN)
    && (cnt != 24'h000000) && ((cnt - 24'h000001) == warn_cmp);
  assign wd_event = expire | feed_err | win_err | prot_err;

  // ********************************
  // counting clock prescaler
  // ********************************
  // the counting clock is a level here; its rising edge is the tick
  assign cc_edge = counting_clock_in & ~cc_q;
  assign dec_en = cc_edge && (presc == PRE_LAST);

  // divide by four; the edge flop tracks the pin in reset, so no false tick
  always_ff @(posedge clk_in) begin
    cc_q <= counting_clock_in;
    if (!reset_n_in) begin
      presc <= 2'h0;
    end else if (cc_edge) begin
      presc <= presc + 2'h1;
    end
  end

  // ********************************
  // crossing into the counting side
  // ********************************
  assign cfg_word = {prot_bit, rst_bit, en_bit, reload};

  // three counting clock stages; the counter only ever sees the last
  for (genvar i = 0; i < CFG_DELAY; i++) begin : g_cfg
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        pipe[i] <= {3'h0, RST_RELOAD};
      end else if (cc_edge) begin
        if (i == 0) begin
          pipe[i] <= cfg_word;
        end else begin
          pipe[i] <= pipe[(i == 0) ? 0 : i - 1];
        end
      end
    end
  end

  // ********************************
  // down counter
  // ********************************
  // a pending feed wins over a decrement on the same tick
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cnt <= RST_CNT;
      run <= 1'b0;
      rst_active <= 1'b0;
    end else if (cc_edge && feed_pend) begin
      cnt <= pipe[CFG_DELAY-1][23:0];
      run <= run | pipe[CFG_DELAY-1][24];
      rst_active <= pipe[CFG_DELAY-1][25];
    end else if (expire) begin
      cnt <= pipe[CFG_DELAY-1][23:0];
    end else if (dec_en && run) begin
      cnt <= cnt - 24'h000001;
    end
  end

  // feed request waits for the next counting tick
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      feed_pend <= 1'b0;
    end else if (feed_ok) begin
      feed_pend <= 1'b1;
    end else if (cc_edge) begin
      feed_pend <= 1'b0;
    end
  end

  // ********************************
  // counter read path
  // ********************************
  // value is locked on the counting side then passed through two flops
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cap <= RST_CNT;
      cap_s1 <= RST_CNT;
      cap_s2 <= RST_CNT;
    end else begin
      if (cc_edge) begin
        cap <= cnt;
      end
      cap_s1 <= cap;
      cap_s2 <= cap_s1;
    end
  end

  // ********************************
  // feed sequence tracker
  // ********************************
  // any access after the first key ends the sequence, good or bad
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fstate <= FD_IDLE;
    end else begin
      case (fstate)
        FD_IDLE: begin
          if (wr && (paddr_in == ADR_FEED) && (pwdata_in[7:0] == FEED_KEY1)) begin
            fstate <= FD_ARMED;
          end
        end
        FD_ARMED: begin
          if (acc) begin
            fstate <= FD_IDLE;
          end
        end
        default: begin
          fstate <= FD_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // mode register
  // ********************************
  // set only: a write of zero never clears a control bit
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      en_bit <= 1'b0;
      rst_bit <= 1'b0;
      prot_bit <= 1'b0;
    end else if (wr_mode) begin
      en_bit <= en_bit | pwdata_in[BIT_EN];
      rst_bit <= rst_bit | pwdata_in[BIT_RST];
      prot_bit <= prot_bit | pwdata_in[BIT_PROT];
    end
  end

  // timeout flag: cleared by an outside reset or a mode write with the bit at zero, event beats clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      if (ext_por_in) begin
        timeout_flag <= 1'b0;
      end
    end else if (wd_event) begin
      timeout_flag <= 1'b1;
    end else if (wr_mode && !pwdata_in[BIT_TOF]) begin
      timeout_flag <= 1'b0;
    end
  end

  // warning flag: write one to clear, a match in the same cycle wins
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      warning_flag <= 1'b0;
    end else if (warn_hit) begin
      warning_flag <= 1'b1;
    end else if (wr_mode && pwdata_in[BIT_WINT]) begin
      warning_flag <= 1'b0;
    end
  end

  assign warning_irq_out = warning_flag;

  // ********************************
  // compare and reload registers
  // ********************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reload <= RST_RELOAD;
      warn_cmp <= RST_WARN;
      window <= RST_WINDOW;
    end else begin
      if (wr_reload && !refuse) begin
        reload <= (pwdata_in[23:0] < MIN_RELOAD) ? MIN_RELOAD : pwdata_in[23:0];
      end
      if (wr && (paddr_in == ADR_WARN)) begin
        warn_cmp <= pwdata_in[23:0];
      end
      if (wr && (paddr_in == ADR_WINDOW)) begin
        window <= pwdata_in[23:0];
      end
    end
  end

  // ********************************
  // chip reset request
  // ********************************
  // held until the system reset it causes comes back around
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      chip_reset_out <= 1'b0;
    end else if (wd_event && rst_active) begin
      chip_reset_out <= 1'b1;
    end
  end

  // ********************************
  // read data and response
  // ********************************
  // read data is prepared in the setup phase so it is a flop output
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
      pready_out <= 1'b0;
    end else begin
      pready_out <= 1'b1;
      if (setup) begin
        pslverr_out <= 1'b0;
        case (paddr_in)
          ADR_MODE: prdata_out <= {27'h0, prot_bit, warning_flag,
            timeout_flag, rst_bit, en_bit};
          ADR_RELOAD: prdata_out <= {8'h00, reload};
          ADR_FEED: prdata_out <= 32'h00000000;
          ADR_VALUE: prdata_out <= {8'h00, cap_s2};
          ADR_WARN: prdata_out <= {8'h00, warn_cmp};
          ADR_WINDOW: prdata_out <= {8'h00, window};
          default: begin
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b1;
          end
        endcase
      end
    end
  end

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_min_reload;
    wr_reload && !refuse && (pwdata_in[23:0] < 24'h0000ff) |=> reload == 24'h0000ff;
  endproperty
  a_min_reload: assert property (p_min_reload) else $error("reload below floor");

  property p_prescale;
    dec_en |=> !dec_en [*3];
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler too fast");

  property p_expire;
    expire |=> timeout_flag;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry not flagged");

  property p_window;
    feed_ok && run && (cnt > window) |=> timeout_flag;
  endproperty
  a_window: assert property (p_window) else $error("early feed missed");

  property p_chip_reset;
    wd_event && rst_active |=> chip_reset_out;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("no chip reset");

  property p_warn;
    warn_hit |=> warning_flag && warning_irq_out;
  endproperty
  a_warn: assert property (p_warn) else $error("warning lost");

  property p_run_sticky;
    run |=> run;
  endproperty
  a_run_sticky: assert property (p_run_sticky) else $error("watchdog stopped");

  property p_feed_err;
    (fstate == FD_ARMED) && acc && !feed_ok && run |=> timeout_flag;
  endproperty
  a_feed_err: assert property (p_feed_err) else $error("feed error missed");

  property p_set_only;
    en_bit |=> en_bit;
  endproperty
  a_set_only: assert property (p_set_only) else $error("enable cleared");

  property p_refused;
    wr_reload && refuse |=> $stable(reload) && timeout_flag;
  endproperty
  a_refused: assert property (p_refused) else $error("locked reload changed");

  c_feed: cover property (feed_ok && !win_err);
  c_expire: cover property (expire && rst_active);
  c_warn: cover property (warn_hit);
  c_window: cover property (win_err);

endmodule // wwd_top

// ==== verif/wwd_apb_host.sv ====
/*
  apb host model standing in for the processor: one transfer per call.
  assumes a slave on clk_in; lines change on the falling edge only.
*/
`timescale 1ns/100ps
module wwd_apb_host (
  input wire logic clk_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [wwd_pkg::ADR_W-1:0] paddr_out,
  output logic [31:0] pwdata_out
);
  import wwd_pkg::*;
  // ********************************
  // idle bus at time zero
  // ********************************
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 8'h00;
    pwdata_out = 32'h0;
  end
  // released address and data lines show the inverse, so a stale value never passes as held
  task automatic xfer(input logic wr, input logic [ADR_W-1:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(negedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    paddr_out <= adr;
    pwdata_out <= wd;
    @(negedge clk_in);
    penable_out <= 1'b1;
    @(posedge clk_in);
    while (pready_in !== 1'b1) @(posedge clk_in);
    rd = prdata_in;
    err = pslverr_in;
    @(negedge clk_in);
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~adr;
    pwdata_out <= ~wd;
  endtask
endmodule // wwd_apb_host

// ==== verif/windowed_watchdog_timer_bench.sv ====
/*
  self-checking bench for the windowed watchdog: apb host model, counting
  clock of four clk periods, resets with and without the outside flag.
  assumes the design answers apb with no wait states and ticks on each
  rise of the counting clock level.
*/
`timescale 1ns/100ps
module windowed_watchdog_timer_bench;
  import wwd_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic ext_por_in = 1'b1;
  logic [1:0] cc_div = 2'h0;
  logic psel, penable, pwrite, pslverr, pready, chip_reset, warn_irq;
  logic [ADR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // ********************************
  // clocks, time limit, instances
  // ********************************
  always #20 clk_in = ~clk_in;
  // counting clock level: two clk high, two low
  always @(negedge clk_in) cc_div <= cc_div + 2'h1;
  // whole run needs about 8800 clk; the ceiling leaves room for slack
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  wwd_top u_wwd_top (.clk_in(clk_in), .reset_n_in(reset_n_in), .ext_por_in(ext_por_in),
    .counting_clock_in(cc_div[1]), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .chip_reset_out(chip_reset), .warning_irq_out(warn_irq));
  wwd_apb_host u_wwd_apb_host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
    .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .paddr_out(paddr), .pwdata_out(pwdata));
  // ********************************
  // shared tasks
  // ********************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADR_W-1:0] adr, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_wwd_apb_host.xfer(1'b1, adr, d, r, e);
  endtask
  task automatic rd(input logic [ADR_W-1:0] adr, output logic [31:0] r);
    logic e;
    u_wwd_apb_host.xfer(1'b0, adr, 32'h0, r, e);
  endtask
  task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [31:0] exp);
    logic [31:0] r;
    rd(adr, r);
    check(r, exp);
  endtask
  // feed, then wait past the three tick config delay before anything else
  task automatic feed();
    wr(ADR_FEED, {24'h0, FEED_KEY1});
    wr(ADR_FEED, {24'h0, FEED_KEY2});
    repeat (16) @(posedge clk_in);
  endtask
  task automatic do_reset(input logic por);
    @(negedge clk_in);
    reset_n_in <= 1'b0;
    ext_por_in <= por;
    repeat (2) @(negedge clk_in);
    reset_n_in <= 1'b1;
    ext_por_in <= 1'b0;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset_values();
    logic [31:0] r;
    logic e;
    rd_chk(ADR_MODE, 32'h0);
    rd_chk(ADR_RELOAD, 32'hff);
    rd_chk(ADR_VALUE, 32'hff);
    rd_chk(ADR_FEED, 32'h0);
    rd_chk(ADR_WARN, 32'h0);
    rd_chk(ADR_WINDOW, 32'hffffff);
    u_wwd_apb_host.xfer(1'b0, 8'h10, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check({31'h0, pready}, 32'h1);
    $display("test reset_values done");
  endtask
  task automatic t_reload_clamp();
    wr(ADR_RELOAD, 32'h10);
    rd_chk(ADR_RELOAD, 32'hff);
    wr(ADR_RELOAD, 32'h100);
    rd_chk(ADR_RELOAD, 32'h100);
    $display("test reload_clamp done");
  endtask
  task automatic t_run_expire();
    logic [31:0] r;
    wr(ADR_WARN, 32'h80);
    wr(ADR_MODE, 32'h1);
    repeat (16) @(posedge clk_in);
    feed();
    repeat (1000) @(posedge clk_in);
    rd(ADR_VALUE, r);
    check({31'h0, r > 32'hb0 && r < 32'hd8}, 32'h1);
    rd_chk(ADR_MODE, 32'h1);
    repeat (3400) @(posedge clk_in);
    check({31'h0, warn_irq}, 32'h1);
    check({31'h0, chip_reset}, 32'h0);
    rd_chk(ADR_MODE, 32'hd);
    wr(ADR_MODE, 32'h8);
    rd_chk(ADR_MODE, 32'h1);
    check({31'h0, warn_irq}, 32'h0);
    $display("test run_expire done");
  endtask
  task automatic t_feed_error();
    logic [31:0] r;
    wr(ADR_FEED, {24'h0, FEED_KEY1});
    rd(ADR_MODE, r);
    rd_chk(ADR_MODE, 32'h5);
    wr(ADR_MODE, 32'h0);
    feed();
    rd_chk(ADR_MODE, 32'h1);
    wr(ADR_WINDOW, 32'h1);
    repeat (16) @(posedge clk_in);
    feed();
    rd_chk(ADR_MODE, 32'h5);
    wr(ADR_WINDOW, 32'hffffff);
    wr(ADR_MODE, 32'h0);
    $display("test feed_error done");
  endtask
  task automatic t_reset_mode();
    int i;
    wr(ADR_MODE, 32'h2);
    repeat (16) @(posedge clk_in);
    feed();
    for (i = 0; i < 5000 && chip_reset !== 1'b1; i++) @(posedge clk_in);
    check({31'h0, chip_reset}, 32'h1);
    do_reset(1'b0);
    check({31'h0, chip_reset}, 32'h0);
    rd_chk(ADR_MODE, 32'h4);
    do_reset(1'b1);
    rd_chk(ADR_MODE, 32'h0);
    $display("test reset_mode done");
  endtask
  task automatic t_protect();
    wr(ADR_MODE, 32'h10);
    repeat (16) @(posedge clk_in);
    wr(ADR_RELOAD, 32'h200);
    rd_chk(ADR_RELOAD, 32'hff);
    rd_chk(ADR_MODE, 32'h14);
    wr(ADR_WARN, 32'h100);
    repeat (16) @(posedge clk_in);
    wr(ADR_RELOAD, 32'h300);
    rd_chk(ADR_RELOAD, 32'h300);
    $display("test protect done");
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (2) @(negedge clk_in);
    reset_n_in <= 1'b1;
    ext_por_in <= 1'b0;
    t_reset_values();
    t_reload_clamp();
    t_run_expire();
    t_feed_error();
    t_reset_mode();
    t_protect();
    finish_test();
  end
endmodule // windowed_watchdog_timer_bench
